// *** verilog/ebc_bus_ctrl.sv ***
// APB register bank and idle-cycle sequencer of the external bus controller
`include "ebc_consts.svh"
// Summary of operation
// RULE1: Byte order flag latched from pin
// RULE2: Reserved bits read zero, writes ignored
// RULE3: Memory pins float in standby unless set
// RULE4: Strobe pins float standby/released unless set
// RULE5: Software initialises areas before accessing them
// RULE6: Eight writable area control registers exist
// RULE7: Write idle: 0,1,2,4 cycles
// RULE8: Cross-space idle: 2,3,5 cycles
// RULE9: Idle counted in bus clocks, next access
module ebc_bus_ctrl (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        byteOrderSelectPin,
    input  wire logic        softStandby,
    input  wire logic        busReleased,
    input  wire logic        accReq,
    input  wire logic [2:0]  accArea,
    input  wire logic        accWrite,
    output logic             accGrant,
    output logic             memPinDriveEn,
    output logic             strobePinDriveEn,
    output logic             littleEndian
);
    ebc_area_if areaPort ();

    logic [31:0]        common;
    logic               strapTaken;
    logic               rdPending;
    logic               rdFromStore;
    logic [31:0]        rdHold;
    ebc_pkg::ebc_state_e state;
    ebc_pkg::ebc_idle_t idleCnt;
    ebc_pkg::ebc_idle_t gapWrite;
    ebc_pkg::ebc_idle_t gapCross;
    ebc_pkg::ebc_area_t lastArea;
    logic               lastWrite;
    logic               lastValid;
    logic               rdErr;
    logic               reqTaken;
    logic               crossDue;
    logic               writeDue;
    logic               grantNow;

    function automatic logic isArea(input logic [11:0] a);
        isArea = (a >= `EBC_OFS_AREA_BASE) && (a < `EBC_OFS_IDLE_STATUS) && (a[1:0] == 2'b00);
    endfunction : isArea

    function automatic logic isMapped(input logic [11:0] a, input logic wr);
        isMapped = (a == `EBC_OFS_COMMON) || isArea(a) || (a == `EBC_OFS_ACCESS_CTRL)
                   || (a == `EBC_OFS_IDLE_STATUS && !wr);
    endfunction : isMapped

    function automatic ebc_pkg::ebc_area_t areaIdx(input logic [11:0] a);
        logic [11:0] d;
        d = a - `EBC_OFS_AREA_BASE;
        areaIdx = d[4:2];
    endfunction : areaIdx

    function automatic ebc_pkg::ebc_idle_t writeGap(input logic [1:0] f);
        unique case (f)
            2'b00: writeGap = `EBC_IDLE_W00;
            2'b01: writeGap = `EBC_IDLE_W01;
            2'b10: writeGap = `EBC_IDLE_W10;
            2'b11: writeGap = `EBC_IDLE_W11;
        endcase
    endfunction : writeGap

    function automatic ebc_pkg::ebc_idle_t crossGap(input logic [1:0] f);
        unique case (f)
            2'b00: crossGap = `EBC_IDLE_X11;
            2'b01: crossGap = `EBC_IDLE_X01;
            2'b10: crossGap = `EBC_IDLE_X10;
            2'b11: crossGap = `EBC_IDLE_X11;
        endcase
    endfunction : crossGap

    wire logic setupRd = psel && !penable && !pwrite;
    wire logic accWr   = psel && penable && pwrite && pready;

    ebc_area_store uStore (
        .clk  (clk),
        .rst  (rst),
        .port (areaPort)
    );

    assign areaPort.writeEn   = accWr && isArea(paddr);
    assign areaPort.writeIdx  = areaIdx(paddr);
    assign areaPort.writeData = pwdata;
    assign areaPort.readIdx   = areaIdx(paddr);
    assign areaPort.selIdx    = lastArea;

    // Common control register
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            common <= 32'h0000_0000;
        end else if (accWr && paddr == `EBC_OFS_COMMON) begin
            common <= pwdata & `EBC_COMMON_RW_MASK; // RULE2
        end
    end

    // Byte order strap caught after reset release
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            strapTaken   <= 1'b0;
            littleEndian <= 1'b0;
        end else if (!strapTaken) begin
            strapTaken   <= 1'b1;
            littleEndian <= byteOrderSelectPin; // RULE1
        end
    end

    // Pin float control
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            memPinDriveEn    <= 1'b0;
            strobePinDriveEn <= 1'b0;
        end else begin
            memPinDriveEn    <= !softStandby || common[`EBC_BIT_MEM_FLOAT]; // RULE3
            strobePinDriveEn <= !(softStandby || busReleased) || common[`EBC_BIT_STB_FLOAT]; // RULE4
        end
    end

    // APB read: one wait state on reads, writes at once
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdPending   <= 1'b0;
            rdFromStore <= 1'b0;
            rdErr       <= 1'b0;
            rdHold      <= 32'h0000_0000;
        end else begin
            rdPending <= setupRd;
            if (setupRd) begin
                rdFromStore <= isArea(paddr);
                rdErr       <= !isMapped(paddr, 1'b0);
                unique case (paddr)
                    `EBC_OFS_COMMON: begin
                        rdHold <= common | (32'h0000_0001 << `EBC_BIT_FIXED_ONE)
                                  | ({31'h0000_0000, littleEndian} << `EBC_BIT_BYTE_ORDER); // RULE1 RULE2
                    end
                    `EBC_OFS_IDLE_STATUS: begin
                        rdHold <= {26'h000_0000, state == ebc_pkg::EBC_GAP, lastValid, idleCnt};
                    end
                    default: begin
                        rdHold <= 32'h0000_0000;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pready  <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel && !penable && pwrite || rdPending;
            prdata  <= rdPending ? (rdFromStore ? areaPort.readData : rdHold) : 32'h0000_0000;
            pslverr <= (psel && !penable && pwrite && !isMapped(paddr, 1'b1)) || (rdPending && rdErr); // RULE6
        end
    end

    // Gaps from fields of the area last accessed
    assign gapWrite = writeGap({areaPort.selWord[`EBC_WIDLE_HI], areaPort.selWord[`EBC_WIDLE_LO]}); // RULE7 RULE9
    assign gapCross = crossGap({areaPort.selWord[`EBC_XIDLE_HI], areaPort.selWord[`EBC_XIDLE_LO]}); // RULE8 RULE9

    // Request taken in idle, held off while an area word is written
    assign reqTaken = state == ebc_pkg::EBC_IDLE && accReq && !areaPort.writeEn;
    assign crossDue = lastValid && accArea != lastArea && gapCross != 4'h0; // RULE8
    assign writeDue = lastValid && lastWrite && gapWrite != 4'h0; // RULE7
    assign grantNow = (reqTaken && !crossDue && !writeDue) || (state == ebc_pkg::EBC_GAP && idleCnt == 4'h0);

    // Sequencer state: idle, gap, one-cycle access
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state <= ebc_pkg::EBC_IDLE;
        end else begin
            unique case (state)
                ebc_pkg::EBC_IDLE: begin
                    if (reqTaken && (crossDue || writeDue)) begin
                        state <= ebc_pkg::EBC_GAP;
                    end else if (reqTaken) begin
                        state <= ebc_pkg::EBC_ACCESS;
                    end
                end
                ebc_pkg::EBC_ACCESS: begin
                    state <= ebc_pkg::EBC_IDLE;
                end
                ebc_pkg::EBC_GAP: begin
                    if (idleCnt == 4'h0) begin
                        state <= ebc_pkg::EBC_ACCESS;
                    end
                end
                default: begin
                    state <= ebc_pkg::EBC_IDLE;
                end
            endcase
        end
    end

    // Idle counter: loaded from the gap field, counted down in bus clocks
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            idleCnt <= 4'h0;
        end else if (reqTaken && crossDue) begin
            idleCnt <= gapCross - 4'h1; // RULE8
        end else if (reqTaken && writeDue) begin
            idleCnt <= gapWrite - 4'h1; // RULE7
        end else if (state == ebc_pkg::EBC_GAP && idleCnt != 4'h0) begin
            idleCnt <= idleCnt - 4'h1; // RULE9
        end
    end

    // One-cycle grant pulse
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            accGrant <= 1'b0;
        end else begin
            accGrant <= grantNow;
        end
    end

    // Area and direction of the access last granted
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            lastArea  <= 3'h0;
            lastWrite <= 1'b0;
            lastValid <= 1'b0;
        end else if (grantNow) begin
            lastArea  <= accArea;
            lastWrite <= accWrite;
            lastValid <= 1'b1;
        end
    end
endmodule : ebc_bus_ctrl

// *** include/ebc_consts.svh ***
// Offsets, field positions, reset values and idle counts of the bus control block
`ifndef EBC_CONSTS_SVH
`define EBC_CONSTS_SVH
`define EBC_OFS_COMMON      12'h000
`define EBC_OFS_AREA_BASE   12'h004
`define EBC_OFS_IDLE_STATUS 12'h024
`define EBC_OFS_ACCESS_CTRL 12'h028
`define EBC_NUM_AREAS       8
`define EBC_BIT_BYTE_ORDER  3
`define EBC_BIT_FIXED_ONE   4
`define EBC_BIT_MEM_FLOAT   1
`define EBC_BIT_STB_FLOAT   0
`define EBC_COMMON_RW_MASK  32'h0000_00E3
`define EBC_AREA_RW_MASK    32'h37FF_FFFF
`define EBC_AREA_RESET      32'h3600_0000
`define EBC_WIDLE_HI        29
`define EBC_WIDLE_LO        28
`define EBC_XIDLE_HI        26
`define EBC_XIDLE_LO        25
`define EBC_IDLE_W00        4'h0
`define EBC_IDLE_W01        4'h1
`define EBC_IDLE_W10        4'h2
`define EBC_IDLE_W11        4'h4
`define EBC_IDLE_X01        4'h2
`define EBC_IDLE_X10        4'h3
`define EBC_IDLE_X11        4'h5
`endif

// *** include/ebc_pkg.sv ***
// Types of the bus control block
package ebc_pkg;
    typedef logic [2:0] ebc_area_t;
    typedef logic [3:0] ebc_idle_t;
    typedef enum logic [1:0] {
        EBC_IDLE,
        EBC_ACCESS,
        EBC_GAP
    } ebc_state_e;
endpackage : ebc_pkg

// *** include/ebc_area_if.sv ***
// Area register store port shared between top and store
interface ebc_area_if;
    logic              writeEn;
    ebc_pkg::ebc_area_t writeIdx;
    logic [31:0]       writeData;
    ebc_pkg::ebc_area_t readIdx;
    logic [31:0]       readData;
    logic [31:0]       selWord;
    ebc_pkg::ebc_area_t selIdx;
    modport store (input writeEn, writeIdx, writeData, readIdx, selIdx, output readData, selWord);
    modport user  (output writeEn, writeIdx, writeData, readIdx, selIdx, input readData, selWord);
endinterface : ebc_area_if

// *** verilog/ebc_area_store.sv ***
// Eight area bus control words with registered read port
`include "ebc_consts.svh"
module ebc_area_store (
    input wire logic    clk,
    input wire logic    rst,
    ebc_area_if.store   port
);
    logic [31:0] words [`EBC_NUM_AREAS];

    genvar g;
    generate
        for (g = 0; g < `EBC_NUM_AREAS; g++) begin : gArea
            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    words[g] <= `EBC_AREA_RESET; // RULE7 RULE8
                end else if (port.writeEn && port.writeIdx == 3'(g)) begin
                    words[g] <= port.writeData & `EBC_AREA_RW_MASK; // RULE2 RULE6
                end
            end
        end
    endgenerate

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            port.readData <= 32'h0000_0000;
        end else begin
            port.readData <= words[port.readIdx];
        end
    end

    assign port.selWord = words[port.selIdx];
endmodule : ebc_area_store

// *** tb/ebc_bus_ctrl_monitor.sv ***
// Port assertions of the bus control block
module ebc_bus_ctrl_monitor (
    input wire logic        clk,
    input wire logic        rst,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        byteOrderSelectPin,
    input wire logic        softStandby,
    input wire logic        busReleased,
    input wire logic        accReq,
    input wire logic        accGrant,
    input wire logic        memPinDriveEn,
    input wire logic        strobePinDriveEn,
    input wire logic        littleEndian
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    wire logic areaAdr = paddr >= 12'h004 && paddr <= 12'h020 && paddr[1:0] == 2'h0;
    wire logic rdCom = pready && !pwrite && paddr == 12'h000;
    a_endian_sample: assert property ($fell(rst) |=> littleEndian == $past(byteOrderSelectPin))
        else $error("byte order not taken from pin");
    a_endian_hold: assert property (!$past(rst, 2) |-> $stable(littleEndian))
        else $error("byte order changed after reset");
    a_endian_read: assert property (rdCom |-> prdata[3] == littleEndian)
        else $error("byte order flag wrong");
    a_common_rsvd: assert property (rdCom |-> prdata[31:8] == 24'h0 && !prdata[2])
        else $error("common reserved bits set");
    a_area_rsvd: assert property (pready && !pwrite && areaAdr |-> prdata[31:30] == 2'h0 && !prdata[27])
        else $error("area reserved bits set");
    a_area_okay: assert property (pready && areaAdr |-> !pslverr)
        else $error("area register refused");
    a_mem_float: assert property (!rst && !softStandby |=> memPinDriveEn)
        else $error("memory pins floated outside standby");
    a_strobe_float: assert property (!rst && !softStandby && !busReleased |=> strobePinDriveEn)
        else $error("strobe pins floated while active");
    a_err_ready: assert property (pslverr |-> pready)
        else $error("error response without ready");
    a_grant_pulse: assert property (accGrant |=> !accGrant)
        else $error("grant longer than one cycle");
    a_grant_cause: assert property (accGrant |-> $past(accReq))
        else $error("grant without request");
endmodule : ebc_bus_ctrl_monitor
bind ebc_bus_ctrl ebc_bus_ctrl_monitor ebc_bus_ctrl_monitor_inst (.*);

// *** tb/ebc_req_model.sv ***
// Requester standing for the external access side
module ebc_req_model (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       go,
    input  wire logic [2:0] goArea,
    input  wire logic       goWrite,
    input  wire logic       accGrant,
    output logic            accReq,
    output logic      [2:0] accArea,
    output logic            accWrite
);
    timeunit 1ns;
    timeprecision 1ps;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            accReq <= 1'b0;
            accArea <= 3'h0;
            accWrite <= 1'b0;
        end else if (accReq && accGrant) begin
            accReq <= 1'b0;
            accArea <= ~accArea;
            accWrite <= ~accWrite;
        end else if (!accReq && go) begin
            accReq <= 1'b1;
            accArea <= goArea;
            accWrite <= goWrite;
        end
    end
endmodule : ebc_req_model

// *** tb/ebc_bus_ctrl_tb.sv ***
// Self-checking bench of the bus control block
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin err_total++; $display("BAD %0t %h %h", $time, a, b); end end
module ebc_bus_ctrl_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, pin = 0;
    logic        stby = 0, rel = 0, go = 0, goW = 0, errF, w, pw;
    logic        pready, pslverr, accReq, accWrite, accGrant, memEn, stbEn, le;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd, av [8];
    logic [2:0]  accArea, goArea = 3'h0;
    logic [3:0]  q;
    int          err_total = 0, compares = 0, prev, a, n;
    initial forever #5 clk = ~clk;
    ebc_bus_ctrl ebc_bus_ctrl_inst (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .byteOrderSelectPin(pin), .softStandby(stby), .busReleased(rel), .accReq(accReq),
        .accArea(accArea), .accWrite(accWrite), .accGrant(accGrant), .memPinDriveEn(memEn),
        .strobePinDriveEn(stbEn), .littleEndian(le));
    ebc_req_model ebc_req_model_inst (.clk(clk), .rst(rst), .go(go), .goArea(goArea), .goWrite(goW),
        .accGrant(accGrant), .accReq(accReq), .accArea(accArea), .accWrite(accWrite));
    task automatic stop_test;
        if (err_total == 0 && compares > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : stop_test
    task automatic apb(input logic wr, input logic [11:0] ad, input logic [31:0] d);
        int k = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= ad;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin @(posedge clk); k++; end while (pready !== 1'b1 && k < 50);
        `CHK(pready, 1'b1)
        rd = prdata;
        errF = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic acc(input int ar, input logic wr);
        go <= 1'b1;
        goArea <= 3'(ar);
        goW <= wr;
        @(posedge clk);
        go <= 1'b0;
        n = 0;
        while (accGrant !== 1'b1 && n < 40) begin @(posedge clk); n++; end
        `CHK(accGrant, 1'b1)
    endtask : acc
    function automatic int expGap(logic [31:0] v, logic wr, logic x);
        if (x) return v[26:25] == 2'h1 ? 4 : v[26:25] == 2'h2 ? 5 : 7;
        if (!wr) return 2;
        return v[29:28] == 2'h3 ? 6 : v[29:28] + 2;
    endfunction : expGap
    initial begin
        #400000;
        err_total++;
        stop_test;
    end
    initial begin
        rd = $urandom(32'hF40F0355);
        @(posedge clk);
        pin <= 1'($urandom);
        repeat (11) @(posedge clk);
        rst <= 1'b0;
        apb(1'b0, 12'h000, 32'h0);
        `CHK(rd, {27'h1, pin, 3'h0})
        `CHK(le, pin)
        apb(1'b1, 12'h000, 32'h0000_00F3);
        apb(1'b0, 12'h000, 32'h0);
        `CHK(rd, {24'h0, 8'hF3} | {28'h0, pin, 3'h0})
        for (int k = 0; k < 16; k++) begin
            q = 4'(k);
            apb(1'b1, 12'h000, {27'h0, 1'b1, 2'h0, q[1:0]});
            stby <= q[2];
            rel <= q[3];
            repeat (2) @(posedge clk);
            `CHK(memEn, !q[2] | q[1])
            `CHK(stbEn, !(q[2] | q[3]) | q[0])
        end
        stby <= 1'b0;
        rel <= 1'b0;
        for (int i = 0; i < 8; i++) begin
            apb(1'b0, 12'(4 + 4 * i), 32'h0);
            `CHK(rd, 32'h3600_0000)
            av[i] = $urandom & 32'h37FF_FFFF;
            av[i][29:28] = 2'(i % 4);
            av[i][26:25] = 2'(i % 3 + 1);
            apb(1'b1, 12'(4 + 4 * i), av[i]);
            apb(1'b0, 12'(4 + 4 * i), 32'h0);
            `CHK(rd, av[i])
        end
        apb(1'b0, 12'h0FC, 32'h0);
        `CHK({errF, rd}, {1'b1, 32'h0})
        prev = -1;
        repeat (60) begin
            a = $urandom % 4;
            w = 1'($urandom);
            acc(a, w);
            if (prev >= 0) `CHK(n, expGap(av[prev], pw, prev != a))
            prev = a;
            pw = w;
        end
        stop_test;
    end
endmodule : ebc_bus_ctrl_tb
